// File: common/pbsram_pkg.sv
// shared types and constants of the pipelined burst sram cycle control.
// assumes a single clock domain; the attached controller samples on ref_clk_i.
package pbsram_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int BYTES = 4;
    localparam int BYTE_W = 9;
    localparam int DATA_W = BYTES * BYTE_W;
    localparam int FIFO_DEPTH = 8;
    localparam int BURST_LO = 2;

    // ---------------------------------------------------------------
    // reset values and fixed codes
    // ---------------------------------------------------------------
    localparam logic ACTIVE_RST = 1'b0;
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic [1:0] CNT_STEP = 2'h1;
    localparam logic [BYTES-1:0] ALL_BYTES = 4'hf;
    localparam logic [BYTES-1:0] NO_BYTES = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

    // ---------------------------------------------------------------
    // registered synchronous pins
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic primary_select_n;
        logic depth_select_high;
        logic depth_select_low_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic byte_write_gate_n;
        logic all_bytes_write_n;
        logic [BYTES-1:0] byte_select_n;
    } pbsram_pins_t;

    // word carried through the read-data queue
    typedef struct packed {
        logic drive;
        logic [DATA_W-1:0] data;
    } pbsram_rword_t;

    localparam int RWORD_W = $bits(pbsram_rword_t);

endpackage

// File: logic/pbsram_ctrl.sv
// cycle control, burst counter, array and pipelined read path of a
// synchronous burst sram; also holds the read-data queue module.
// assumes ref_clk_i is the sram clock and all synchronous pins meet setup to it.
`timescale 1ns/100ps

// ---------------------------------------------------------------
// read-data queue
// ---------------------------------------------------------------
module pbsram_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    // wrapping pointers only serve power-of-two depths
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_params
        $error("pbsram_fifo: depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? wr_ptr + PW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + PW'(1) : rd_ptr;
        next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    end

    assign in_ready_o = (count != (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; contents are only read behind count
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // pbsram_fifo

// Notes on behaviour
// - primary enable is active low; low is needed to select on a new access
// - primary enable high blocks the processor strobe; controller strobe then deselects
// - second depth enable active high; low prevents selection
// - third depth enable active low; high prevents selection
// - burst order low gives linear sequence, high gives interleaved
// - output enable low drives the data pins, high floats them
// - output enable is not clocked and acts at once; here it passes two synchroniser flops and the output register
// - write when global write low, or gate low with any byte select low
// - enabled processor strobe, or controller strobe without write, begins a read
// - no strobe taken and advance low continues a read at next address
// - no strobe taken and advance high holds the address, read or write
// - write begins at current address or, via controller strobe, external one
// - no strobe, advance low and write continues write at next address
// - linear order adds the burst count to the low two bits
// - interleaved order xors the burst count into the low two bits
// - global write stores all four bytes regardless of other write pins
// - either strobe starts read, write or deselect, save the processor strobe with primary enable high
// - each advance sampled in an active burst with no strobe taken steps the two-bit burst count
module pbsram_ctrl (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [pbsram_pkg::ADDR_W-1:0] sync_address_in_i,
    input wire logic primary_select_n_i,
    input wire logic depth_select_high_i,
    input wire logic depth_select_low_n_i,
    input wire logic proc_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic byte_write_gate_n_i,
    input wire logic all_bytes_write_n_i,
    input wire logic [pbsram_pkg::BYTES-1:0] byte_select_n_i,
    input wire logic burst_order_select_i,
    input wire logic out_enable_n_i,
    input wire logic [pbsram_pkg::DATA_W-1:0] data_io_byte_i,
    output logic [pbsram_pkg::DATA_W-1:0] data_io_byte_o,
    output logic [pbsram_pkg::BYTES-1:0] data_io_byte_oe_o
);
    // ---------------------------------------------------------------
    // input registers and synchronisers
    // ---------------------------------------------------------------
    pbsram_pkg::pbsram_pins_t in_q, next_in_q;
    logic oe_meta, oe_sync, order_meta, order_sync;

    always_comb begin
        next_in_q.addr = sync_address_in_i;
        next_in_q.data = data_io_byte_i;
        next_in_q.primary_select_n = primary_select_n_i;
        next_in_q.depth_select_high = depth_select_high_i;
        next_in_q.depth_select_low_n = depth_select_low_n_i;
        next_in_q.proc_addr_strobe_n = proc_addr_strobe_n_i;
        next_in_q.ctrl_addr_strobe_n = ctrl_addr_strobe_n_i;
        next_in_q.burst_advance_n = burst_advance_n_i;
        next_in_q.byte_write_gate_n = byte_write_gate_n_i;
        next_in_q.all_bytes_write_n = all_bytes_write_n_i;
        next_in_q.byte_select_n = byte_select_n_i;
    end

    // output enable and burst order are asynchronous pins; two flops
    // are the price of keeping every output registered
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_q <= '1;
            oe_meta <= 1'b1;
            oe_sync <= 1'b1;
            order_meta <= 1'b0;
            order_sync <= 1'b0;
        end else begin
            in_q <= next_in_q;
            oe_meta <= out_enable_n_i;
            oe_sync <= oe_meta;
            order_meta <= burst_order_select_i;
            order_sync <= order_meta;
        end
    end

    // ---------------------------------------------------------------
    // cycle decode
    // ---------------------------------------------------------------
    logic ce_ok, desel, begin_ext, wr_req, op_rd, op_wr;
    logic [pbsram_pkg::BYTES-1:0] byte_wr;

    always_comb begin
        ce_ok = !in_q.primary_select_n && in_q.depth_select_high
            && !in_q.depth_select_low_n;
        wr_req = !in_q.all_bytes_write_n
            || (!in_q.byte_write_gate_n && !(&in_q.byte_select_n));
        if (!in_q.all_bytes_write_n) begin
            byte_wr = pbsram_pkg::ALL_BYTES;
        end else if (!in_q.byte_write_gate_n) begin
            byte_wr = ~in_q.byte_select_n;
        end else begin
            byte_wr = pbsram_pkg::NO_BYTES;
        end
        desel = (!in_q.ctrl_addr_strobe_n && in_q.primary_select_n)
            || (!in_q.proc_addr_strobe_n && !in_q.primary_select_n && !ce_ok)
            || (in_q.proc_addr_strobe_n && !in_q.ctrl_addr_strobe_n && !ce_ok);
        // a strobe taken with all enables active
        begin_ext = ce_ok
            && (!in_q.proc_addr_strobe_n || !in_q.ctrl_addr_strobe_n);
    end

    // ---------------------------------------------------------------
    // burst state
    // ---------------------------------------------------------------
    logic active, next_active;
    logic [pbsram_pkg::ADDR_W-1:0] base, next_base, acc_addr;
    logic [1:0] cnt, next_cnt, lo_bits;

    always_comb begin
        next_active = active;
        next_base = base;
        next_cnt = cnt;
        op_rd = 1'b0;
        op_wr = 1'b0;
        if (desel) begin
            next_active = 1'b0;
        end else if (begin_ext) begin
            next_active = 1'b1;
            next_base = in_q.addr;
            next_cnt = pbsram_pkg::CNT_RST;
            // processor strobe always begins a read
            op_rd = !in_q.proc_addr_strobe_n || !wr_req;
            // controller strobe with write begins at external address
            op_wr = in_q.proc_addr_strobe_n && wr_req;
        end else if (active) begin
            if (!in_q.burst_advance_n) begin
                next_cnt = cnt + pbsram_pkg::CNT_STEP;
            end
            // advance high keeps the current address
            op_wr = wr_req;
            op_rd = !wr_req;
        end
        if (order_sync) begin
            lo_bits = next_base[1:0] ^ next_cnt;
        end else begin
            lo_bits = next_base[1:0] + next_cnt;
        end
        acc_addr = {next_base[pbsram_pkg::ADDR_W-1:pbsram_pkg::BURST_LO], lo_bits};
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active <= pbsram_pkg::ACTIVE_RST;
            base <= pbsram_pkg::ADDR_RST;
            cnt <= pbsram_pkg::CNT_RST;
        end else begin
            active <= next_active;
            base <= next_base;
            cnt <= next_cnt;
        end
    end

    // ---------------------------------------------------------------
    // array
    // ---------------------------------------------------------------
    localparam int WORDS = 1 << pbsram_pkg::ADDR_W;
    logic [pbsram_pkg::DATA_W-1:0] array_mem [WORDS];
    logic [pbsram_pkg::DATA_W-1:0] rd_q;
    logic rd_tag;

    // write is self-timed on the edge; array holds no reset
    always_ff @(posedge ref_clk_i) begin
        for (int b = 0; b < pbsram_pkg::BYTES; b++) begin
            if (op_wr && byte_wr[b]) begin
                array_mem[acc_addr][b*pbsram_pkg::BYTE_W +: pbsram_pkg::BYTE_W] <=
                    in_q.data[b*pbsram_pkg::BYTE_W +: pbsram_pkg::BYTE_W];
            end
        end
        rd_q <= array_mem[acc_addr];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_tag <= 1'b0;
        end else begin
            rd_tag <= op_rd;
        end
    end

    // ---------------------------------------------------------------
    // read queue and output register
    // ---------------------------------------------------------------
    pbsram_pkg::pbsram_rword_t q_in, q_out, out_q, next_out_q;
    logic q_in_ready, q_out_valid;
    logic [pbsram_pkg::BYTES-1:0] next_oe;

    assign q_in.drive = rd_tag;
    assign q_in.data = rd_q;

    // one word per cycle in and out; a full queue would drop the pushed word
    pbsram_fifo #(
        .WIDTH(pbsram_pkg::RWORD_W),
        .DEPTH(pbsram_pkg::FIFO_DEPTH)
    ) u_rdq (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(1'b1),
        .in_ready_o(q_in_ready),
        .in_data_i(q_in),
        .out_valid_o(q_out_valid),
        .out_ready_i(1'b1),
        .out_data_o(q_out)
    );

    always_comb begin
        next_out_q = out_q;
        if (q_out_valid) begin
            next_out_q = q_out;
        end
        // drive only a read word with enable low
        next_oe = {pbsram_pkg::BYTES{!oe_sync && next_out_q.drive}};
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= '0;
            data_io_byte_o <= pbsram_pkg::DATA_RST;
            data_io_byte_oe_o <= pbsram_pkg::NO_BYTES;
        end else begin
            out_q <= next_out_q;
            data_io_byte_o <= next_out_q.data;
            data_io_byte_oe_o <= next_oe;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_read_issue;
        op_rd ##1 rd_tag;
    endsequence

    sequence s_burst_step;
        active && !desel && !begin_ext && !in_q.burst_advance_n;
    endsequence

    AST_PSE_BLOCKS: assert property (
        in_q.primary_select_n && !in_q.ctrl_addr_strobe_n |=> !active)
        else $error("controller strobe with primary enable high did not deselect");
    AST_DEPTH_ENABLES: assert property (
        (in_q.depth_select_low_n || !in_q.depth_select_high) |-> !begin_ext)
        else $error("access began with a depth enable inactive");
    AST_BEGIN_LOADS: assert property (
        begin_ext && !desel |=> active && base == $past(in_q.addr) && cnt == 2'h0)
        else $error("begin did not load the external address");
    AST_ADV_STEP: assert property (
        s_burst_step |=> cnt == $past(cnt) + 2'h1)
        else $error("advance did not step the burst count");
    AST_SUSPEND_HOLD: assert property (
        active && !desel && !begin_ext && in_q.burst_advance_n |=> $stable(cnt)
            && $stable(base))
        else $error("suspend moved the burst address");
    AST_GLOBAL_ALL: assert property (
        !in_q.all_bytes_write_n |-> byte_wr == 4'hf && wr_req)
        else $error("global write did not cover all bytes");
    AST_READ_LATENCY: assert property (
        s_read_issue |-> ##2 out_q.drive)
        else $error("read word missing from the output register");
    AST_WRITE_FLOATS: assert property (
        op_wr |-> ##3 data_io_byte_oe_o == 4'h0)
        else $error("data pins driven during a write");
    AST_OE_HIGH_FLOATS: assert property (
        oe_sync [*2] |=> data_io_byte_oe_o == 4'h0)
        else $error("data pins driven with output enable high");
    AST_INTERLEAVE: assert property (
        order_sync && s_burst_step |-> acc_addr[1:0] == (base[1:0] ^ (cnt + 2'h1)))
        else $error("interleaved burst address wrong");
    AST_LINEAR: assert property (
        !order_sync && s_burst_step |-> acc_addr[1:0] == (base[1:0] + cnt + 2'h1))
        else $error("linear burst address wrong");
    // queue drains every cycle, so a full queue means a lost read word
    AST_RDQ_ROOM: assert property (
        q_in_ready)
        else $error("read queue full");
endmodule // pbsram_ctrl

// File: testbench/pbsram_host.sv
// controller-side model that drives the synchronous sram pins once per clock.
// assumes the bench calls drive() a fixed small delay after each rising edge.
`timescale 1ns/100ps

module pbsram_host (
    input wire logic ref_clk_i,
    output pbsram_pkg::pbsram_pins_t pins_o,
    output logic burst_order_select_o,
    output logic out_enable_n_o
);
    pbsram_pkg::pbsram_pins_t cur;
    logic order = 1'b0;
    int guard = 0;
    logic [pbsram_pkg::DATA_W-1:0] last = '0;

    assign pins_o = cur;
    assign burst_order_select_o = order;
    assign out_enable_n_o = (guard != 0);

    initial begin
        cur = '1;
    end

    task automatic drive(input pbsram_pkg::pbsram_pins_t p);
        logic wr;
        wr = !p.all_bytes_write_n || (!p.byte_write_gate_n && p.byte_select_n != 4'hf);
        cur = p;
        if (wr) begin
            last = p.data;
            guard = 2;
        end else begin
            // a released bus must not keep showing the last written word
            cur.data = ~last;
            last = ~last;
            if (guard != 0) guard--;
        end
    endtask

    // order pin only moved while deselected
    task automatic set_order(input logic o);
        order = o;
    endtask
endmodule // pbsram_host

// File: testbench/tb_top.sv
// self-checking bench: random controller traffic against a model keyed by cycle.
// assumes one clock and that output enable reaches the pins a few edges late.
`timescale 1ns/100ps

module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    pbsram_pkg::pbsram_pins_t pins;
    pbsram_pkg::pbsram_pins_t p;
    logic order;
    logic oe_n;
    logic [pbsram_pkg::DATA_W-1:0] data_o;
    logic [pbsram_pkg::BYTES-1:0] oe_o;
    logic [pbsram_pkg::DATA_W-1:0] mem [int];
    logic [pbsram_pkg::DATA_W-1:0] exp_rd [int];
    logic act = 1'b0;
    logic [pbsram_pkg::ADDR_W-1:0] base = '0;
    logic [1:0] cnt = 2'h0;
    logic [10:0] hi;
    logic [31:0] s;
    logic last_oe = 1'b1;
    int cyc = 0;
    int oe_chg = 0;
    int fail_count = 0;
    int num_checks = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    pbsram_host u_host (
        .ref_clk_i(ref_clk_i),
        .pins_o(pins),
        .burst_order_select_o(order),
        .out_enable_n_o(oe_n)
    );

    pbsram_ctrl u_dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .sync_address_in_i(pins.addr),
        .primary_select_n_i(pins.primary_select_n),
        .depth_select_high_i(pins.depth_select_high),
        .depth_select_low_n_i(pins.depth_select_low_n),
        .proc_addr_strobe_n_i(pins.proc_addr_strobe_n),
        .ctrl_addr_strobe_n_i(pins.ctrl_addr_strobe_n),
        .burst_advance_n_i(pins.burst_advance_n),
        .byte_write_gate_n_i(pins.byte_write_gate_n),
        .all_bytes_write_n_i(pins.all_bytes_write_n),
        .byte_select_n_i(pins.byte_select_n),
        .burst_order_select_i(order),
        .out_enable_n_i(oe_n),
        .data_io_byte_i(pins.data),
        .data_io_byte_o(data_o),
        .data_io_byte_oe_o(oe_o)
    );

    // ---------------------------------------------------------------
    // comparison and closing
    // ---------------------------------------------------------------
    task automatic chk_data(input logic [pbsram_pkg::DATA_W-1:0] e,
                            input logic [pbsram_pkg::DATA_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error read data: expected %h, seen %h", e, g);
        end
    endtask

    task automatic chk_oe(input logic [pbsram_pkg::BYTES-1:0] e,
                          input logic [pbsram_pkg::BYTES-1:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error output enable: expected %h, seen %h", e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // reference model of one sampled cycle
    // ---------------------------------------------------------------
    task automatic model(input pbsram_pkg::pbsram_pins_t q);
        logic en;
        logic dis;
        logic wr;
        logic go;
        logic rd;
        logic [pbsram_pkg::ADDR_W-1:0] a;
        en = !q.primary_select_n && q.depth_select_high && !q.depth_select_low_n;
        dis = !q.depth_select_high || q.depth_select_low_n;
        wr = !q.all_bytes_write_n || (!q.byte_write_gate_n && q.byte_select_n != 4'hf);
        go = 1'b0;
        rd = 1'b1;
        if ((!q.ctrl_addr_strobe_n && q.primary_select_n) ||
            (!q.proc_addr_strobe_n && !q.primary_select_n && dis) ||
            (!q.ctrl_addr_strobe_n && dis)) begin
            act = 1'b0;
        end else if (en && (!q.proc_addr_strobe_n || !q.ctrl_addr_strobe_n)) begin
            act = 1'b1;
            base = q.addr;
            cnt = pbsram_pkg::CNT_RST;
            go = 1'b1;
            rd = !q.proc_addr_strobe_n || !wr;
        end else if (act) begin
            if (!q.burst_advance_n) cnt = cnt + pbsram_pkg::CNT_STEP;
            go = 1'b1;
            rd = !wr;
        end
        a = {base[pbsram_pkg::ADDR_W-1:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
        // sampled next edge: array, queue, output register follow
        if (go && rd) exp_rd[cyc + 4] = mem[a];
        if (go && !rd) begin
            for (int b = 0; b < pbsram_pkg::BYTES; b++) begin
                if (!q.all_bytes_write_n || !q.byte_select_n[b]) begin
                    mem[a][pbsram_pkg::BYTE_W*b +: pbsram_pkg::BYTE_W] =
                        q.data[pbsram_pkg::BYTE_W*b +: pbsram_pkg::BYTE_W];
                end
            end
        end
    endtask

    // ---------------------------------------------------------------
    // one clock of stimulus
    // ---------------------------------------------------------------
    task automatic tick(input pbsram_pkg::pbsram_pins_t q);
        logic due;
        @(posedge ref_clk_i);
        #1;
        cyc++;
        if (oe_n !== last_oe) begin
            oe_chg = cyc;
            last_oe = oe_n;
        end
        due = exp_rd.exists(cyc);
        // only judged once the enable has settled through its synchroniser
        if (cyc - oe_chg >= 5) begin
            chk_oe((due && !oe_n) ? pbsram_pkg::ALL_BYTES : pbsram_pkg::NO_BYTES, oe_o);
        end
        if (due) begin
            chk_data(exp_rd[cyc], data_o);
            exp_rd.delete(cyc);
        end
        u_host.drive(q);
        model(u_host.cur);
    endtask

    function automatic pbsram_pkg::pbsram_pins_t rnd_pins();
        pbsram_pkg::pbsram_pins_t r;
        logic [63:0] d;
        d = {$urandom(), $urandom()};
        r.addr = {hi, d[39:36]};
        r.data = d[pbsram_pkg::DATA_W-1:0];
        r.primary_select_n = ($urandom() % 8 == 0);
        r.depth_select_high = ($urandom() % 8 != 0);
        r.depth_select_low_n = ($urandom() % 8 == 0);
        r.proc_addr_strobe_n = ($urandom() % 4 != 0);
        r.ctrl_addr_strobe_n = ($urandom() % 4 != 0);
        r.burst_advance_n = d[40];
        r.byte_write_gate_n = ($urandom() % 8 != 0);
        r.all_bytes_write_n = ($urandom() % 16 != 0);
        r.byte_select_n = d[63:60];
        return r;
    endfunction

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h0000_ed46));
        s = $urandom();
        hi = s[10:0];
        repeat (12) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        chk_oe(pbsram_pkg::NO_BYTES, oe_o);
        // global-write bursts fill the sixteen words that random traffic uses
        for (int g = 0; g < 4; g++) begin
            p = '1;
            p.ctrl_addr_strobe_n = 1'b0;
            p.primary_select_n = 1'b0;
            p.depth_select_low_n = 1'b0;
            p.all_bytes_write_n = 1'b0;
            p.addr = {hi, g[1:0], 2'b00};
            for (int k = 0; k < 4; k++) begin
                s = $urandom();
                p.data = {s[3:0], $urandom()};
                tick(p);
                p.ctrl_addr_strobe_n = 1'b1;
                p.burst_advance_n = 1'b0;
            end
        end
        p = '1;
        p.ctrl_addr_strobe_n = 1'b0;
        for (int o = 0; o < 2; o++) begin
            repeat (8) tick(p);
            u_host.set_order(o[0]);
            repeat (8) tick(p);
            repeat (400) tick(rnd_pins());
        end
        repeat (10) tick('1);
        tally_and_finish();
    end

    initial begin
        #50000;
        $display("Error watchdog: expected end of run, seen timeout");
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_top
